// ---- fmg_top.sv ----
// Flash modify guard, supply interlock, read path power control
`timescale 1ns/10ps
module fmg_top
   import fmg_pkg::*;
#(
   parameter int AW      = FMG_ADDR_W,
   parameter int ROW     = FMG_ROW_BYTES,
   parameter int PROG    = FMG_PROG_CYC,
   parameter int ARR_AW  = 9
) (
   // Clock and reset
   input  wire logic          clock,
   input  wire logic          rst_n,
   input  wire logic          por_event,
   // Register port
   input  wire logic [7:0]    reg_addr,
   input  wire logic [7:0]    reg_wdata,
   input  wire logic          reg_wr,
   input  wire logic          reg_rd,
   output logic [7:0]         reg_rdata,
   // Code space read and external-data write
   input  wire logic          code_rd,
   input  wire logic          code_fetch,
   input  wire logic [AW-1:0] code_addr,
   output logic [7:0]         code_rdata,
   output logic               code_rdata_bad,
   input  wire logic          xdata_wr,
   input  wire logic [AW-1:0] xdata_addr,
   input  wire logic [7:0]    xdata_wdata,
   // Interrupts and idle
   input  wire logic          irq_in,
   output logic               irq_hold,
   input  wire logic          idle_wake,
   output logic               core_run,
   // Status
   output logic               flash_busy,
   output logic               fault_reset_req,
   output logic               sense_enable,
   output logic               row_change
);
   typedef struct packed {
      logic [7:0]    psc;
      logic [7:0]    scale;
      logic          sm_en;
      logic          sm_rst;
      logic          ferr;
      logic          por_flag;
      fmg_key_t      key;
      fmg_op_t       op;
      logic [2:0]    op_cnt;
      logic          fault;
      logic [1:0]    wake_cnt;
      logic          waking;
      logic          rd_pend;
      logic          rd_id;
      logic [AW-1:0] last_addr;
      logic          row_chg;
      logic [7:0]    rdata;
   } fmg_state_t;

   fmg_state_t st_r;
   fmg_state_t st_nxt;

   logic [7:0] arr_rdata;
   logic       os_bad;
   logic       modify_ok;
   logic       arr_wr;
   logic       arr_erase;

   wire logic we = st_r.psc[FMG_PSC_WE_BIT];
   wire logic ee = st_r.psc[FMG_PSC_EE_BIT];

   // Interlock evaluated at the access, on live monitor settings
   assign modify_ok = st_r.sm_en && st_r.sm_rst && (st_r.key == FMG_K_OPEN);
   assign arr_wr    = xdata_wr && we && !ee && modify_ok && (st_r.op == FMG_OP_IDLE);
   assign arr_erase = xdata_wr && we && ee && modify_ok && (st_r.op == FMG_OP_IDLE);

   always_comb begin
      st_nxt         = st_r;
      st_nxt.fault   = 1'b0;
      st_nxt.rdata   = 8'h00;
      st_nxt.rd_pend = code_rd;
      st_nxt.row_chg = 1'b0;
      // Register writes
      if (reg_wr) begin
         unique case (reg_addr)
            FMG_ADDR_PSC: begin
               st_nxt.psc = {5'h00, reg_wdata[2:0]};
            end
            FMG_ADDR_SCALE: begin
               st_nxt.scale = reg_wdata & (8'h01 << FMG_SCALE_BYP_BIT);
            end
            FMG_ADDR_KEY: begin
               if (st_r.key == FMG_K_LOCK && reg_wdata == FMG_KEY1) begin
                  st_nxt.key = FMG_K_HALF;
               end else if (st_r.key == FMG_K_HALF && reg_wdata == FMG_KEY2) begin
                  st_nxt.key = FMG_K_OPEN;
               end else begin
                  st_nxt.key = FMG_K_LOCK;
               end
            end
            FMG_ADDR_RSTCAUSE: begin
               st_nxt.sm_rst = reg_wdata[FMG_RC_SUP_BIT];
            end
            FMG_ADDR_SUPMON: begin
               st_nxt.sm_en = reg_wdata[FMG_SM_EN_BIT];
            end
            default: begin
            end
         endcase
      end
      // Any external-data write with write enable consumes the unlock
      if (xdata_wr && we) begin
         st_nxt.key = FMG_K_LOCK;
         if (!(st_r.sm_en && st_r.sm_rst)) begin
            st_nxt.fault = 1'b1;
            st_nxt.ferr  = 1'b1;
         end else if (arr_erase) begin
            st_nxt.op     = FMG_OP_ERASE;
            st_nxt.op_cnt = 3'(PROG - 1);
         end else if (arr_wr) begin
            st_nxt.op     = FMG_OP_WRITE;
            st_nxt.op_cnt = 3'(PROG - 1);
         end
      end
      // Operation timer; interrupts held while it runs
      if (st_r.op != FMG_OP_IDLE) begin
         if (st_r.op_cnt == 3'h0) begin
            st_nxt.op = FMG_OP_IDLE;
         end else begin
            st_nxt.op_cnt = st_r.op_cnt - 3'h1;
         end
      end
      // Idle wake counts three clocks
      if (idle_wake && !st_r.waking) begin
         st_nxt.waking   = 1'b1;
         st_nxt.wake_cnt = 2'(FMG_WAKE_CYC - 1);
      end else if (st_r.waking) begin
         if (st_r.wake_cnt == 2'h0) begin
            st_nxt.waking = 1'b0;
         end else begin
            st_nxt.wake_cnt = st_r.wake_cnt - 2'h1;
         end
      end
      // Code read path
      if (code_rd) begin
         st_nxt.rd_id     = (code_addr == AW'(FMG_ID_ADDR)) && !st_r.psc[FMG_PSC_SP_BIT];
         st_nxt.last_addr = code_addr;
         st_nxt.row_chg   = (code_addr / AW'(ROW)) != (st_r.last_addr / AW'(ROW));
      end
      // Register reads
      if (reg_rd) begin
         unique case (reg_addr)
            FMG_ADDR_PSC:      st_nxt.rdata = st_r.psc;
            FMG_ADDR_SCALE:    st_nxt.rdata = st_r.scale;
            FMG_ADDR_RSTCAUSE: begin
               st_nxt.rdata[FMG_RC_FERR_BIT] = st_r.ferr;
               st_nxt.rdata[FMG_RC_SUP_BIT]  = st_r.sm_rst;
            end
            FMG_ADDR_SUPMON: begin
               st_nxt.rdata[FMG_SM_EN_BIT] = st_r.sm_en;
            end
            default:           st_nxt.rdata = 8'h00;
         endcase
      end
      // Power-on restores monitor and its reset source
      if (por_event) begin
         st_nxt.sm_en  = 1'b1;
         st_nxt.sm_rst = 1'b1;
         // A fault in the same cycle keeps the flag set
         st_nxt.ferr   = st_nxt.fault;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st_r        <= '0;
         st_r.psc    <= FMG_PSC_RST;
         st_r.scale  <= FMG_SCALE_RST;
         st_r.sm_en  <= 1'b1;
         st_r.sm_rst <= 1'b1;
         st_r.key    <= FMG_K_LOCK;
         st_r.op     <= FMG_OP_IDLE;
      end else begin
         st_r <= st_nxt;
      end
   end

   fmg_oneshot u_os (
      .clock        (clock),
      .rst_n        (rst_n),
      .bypass       (st_r.scale[FMG_SCALE_BYP_BIT]),
      .access       (code_rd),
      .opcode_fetch (code_fetch && code_rd),
      .sense_enable (sense_enable),
      .fetch_bad    (os_bad)
   );

   fmg_array #(
      .AW   (ARR_AW),
      .PAGE (FMG_PAGE_BYTES)
   ) u_arr (
      .clock (clock),
      .rst_n (rst_n),
      .wr    (arr_wr),
      .erase (arr_erase),
      .waddr (xdata_addr[ARR_AW-1:0]),
      .wdata (xdata_wdata),
      .raddr (code_addr[ARR_AW-1:0]),
      .rdata (arr_rdata)
   );

   assign reg_rdata       = st_r.rdata;
   assign code_rdata      = st_r.rd_id ? FMG_ID_VALUE : arr_rdata;
   assign code_rdata_bad  = os_bad;
   assign flash_busy      = st_r.op != FMG_OP_IDLE;
   assign irq_hold        = irq_in && (st_r.op != FMG_OP_IDLE);
   assign core_run        = !st_r.waking;
   assign fault_reset_req = st_r.fault;
   assign row_change      = st_r.row_chg;
endmodule

// ---- fmg_pkg.sv ----
// Package: constants and types for the flash modify guard and read power block
package fmg_pkg;
   // Address map of the core-side register port
   localparam logic [7:0]  FMG_ADDR_PSC      = 8'h8F;
   localparam logic [7:0]  FMG_ADDR_SCALE    = 8'hB6;
   localparam logic [7:0]  FMG_ADDR_KEY      = 8'hB7;
   localparam logic [7:0]  FMG_ADDR_RSTCAUSE = 8'hEF;
   localparam logic [7:0]  FMG_ADDR_SUPMON   = 8'hFF;
   localparam logic [7:0]  FMG_ADDR_DUMMY    = 8'hE5;
   // Field positions
   localparam int          FMG_PSC_WE_BIT    = 0;
   localparam int          FMG_PSC_EE_BIT    = 1;
   localparam int          FMG_PSC_SP_BIT    = 2;
   localparam int          FMG_SCALE_BYP_BIT = 6;
   localparam int          FMG_RC_POR_BIT    = 1;
   localparam int          FMG_RC_SUP_BIT    = 1;
   localparam int          FMG_RC_FERR_BIT   = 6;
   localparam int          FMG_SM_EN_BIT     = 7;
   // Reset values
   localparam logic [7:0]  FMG_PSC_RST       = 8'h00;
   localparam logic [7:0]  FMG_SCALE_RST     = 8'h00;
   localparam logic [7:0]  FMG_SUPMON_RST    = 8'h80;
   // Unlock keys
   localparam logic [7:0]  FMG_KEY1          = 8'hA5;
   localparam logic [7:0]  FMG_KEY2          = 8'hF1;
   // Part identification location; value is arbitrary
   localparam logic [13:0] FMG_ID_ADDR       = 14'h3FFE;
   localparam logic [7:0]  FMG_ID_VALUE      = 8'h5A;
   // Geometry
   localparam int          FMG_ADDR_W        = 14;
   localparam int          FMG_ROW_BYTES     = 64;
   localparam int          FMG_PAGE_BYTES    = 512;
   // Timing at 40 MHz
   localparam int          FMG_CLK_PS        = 25000;
   localparam int          FMG_OS_PS         = 25000;
   localparam int          FMG_OS_CYC        = (FMG_OS_PS + FMG_CLK_PS - 1) / FMG_CLK_PS;
   localparam int          FMG_WAKE_CYC      = 3;
   localparam int          FMG_HAZ_FETCH     = 3;
   localparam int          FMG_PROG_CYC      = 4;
   // Key sequence state
   typedef enum logic [1:0] {
      FMG_K_LOCK  = 2'b00,
      FMG_K_HALF  = 2'b01,
      FMG_K_OPEN  = 2'b10
   } fmg_key_t;
   // Array operation state
   typedef enum logic [1:0] {
      FMG_OP_IDLE  = 2'b00,
      FMG_OP_WRITE = 2'b01,
      FMG_OP_ERASE = 2'b10
   } fmg_op_t;
endpackage

// ---- fmg_oneshot.sv ----
// Sense amplifier enable one-shot with bypass and re-enable hazard tracking
`timescale 1ns/10ps
module fmg_oneshot
   import fmg_pkg::*;
#(
   parameter int OS_CYC  = FMG_OS_CYC,
   parameter int HAZ_CNT = FMG_HAZ_FETCH
) (
   // Clock and reset
   input  wire logic clock,
   input  wire logic rst_n,
   // Control
   input  wire logic bypass,
   input  wire logic access,
   input  wire logic opcode_fetch,
   // Outputs
   output logic      sense_enable,
   output logic      fetch_bad
);
   typedef struct packed {
      logic       byp_d;
      logic [3:0] os_cnt;
      logic [1:0] haz_cnt;
      logic       haz_arm;
      logic       bad;
   } fmg_os_state_t;

   fmg_os_state_t st_r;
   fmg_os_state_t st_nxt;

   always_comb begin
      st_nxt       = st_r;
      st_nxt.byp_d = bypass;
      st_nxt.bad   = 1'b0;
      // Enable pulse starts on each access and lasts the minimum length
      if (access) begin
         st_nxt.os_cnt = 4'(OS_CYC - 1);
      end else if (st_r.os_cnt != 4'h0) begin
         st_nxt.os_cnt = st_r.os_cnt - 4'h1;
      end
      // Falling edge of bypass arms the bad third fetch
      if (st_r.byp_d && !bypass) begin
         st_nxt.haz_arm = 1'b1;
         st_nxt.haz_cnt = 2'h0;
      end else if (st_r.haz_arm && opcode_fetch) begin
         if (st_r.haz_cnt == 2'(HAZ_CNT - 1)) begin
            st_nxt.haz_arm = 1'b0;
            st_nxt.bad     = 1'b1;
         end else begin
            st_nxt.haz_cnt = st_r.haz_cnt + 2'h1;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Bypassed: enable follows access for the whole cycle
   assign sense_enable = bypass ? access : (access | (st_r.os_cnt != 4'h0));
   assign fetch_bad    = st_r.bad;
endmodule

// ---- fmg_array.sv ----
// Small flash array model: byte program, page erase, registered read
`timescale 1ns/10ps
module fmg_array
   import fmg_pkg::*;
#(
   parameter int AW   = 9,
   parameter int PAGE = FMG_PAGE_BYTES
) (
   // Clock and reset
   input  wire logic          clock,
   input  wire logic          rst_n,
   // Access
   input  wire logic          wr,
   input  wire logic          erase,
   input  wire logic [AW-1:0] waddr,
   input  wire logic [7:0]    wdata,
   input  wire logic [AW-1:0] raddr,
   output logic [7:0]         rdata
);
   logic [7:0] mem [2**AW];
   logic [7:0] rdata_r;

   always_ff @(posedge clock) begin
      for (int i = 0; i < 2**AW; i++) begin
         // Page index in integers: a page may span the whole array
         if (erase && ((i / PAGE) == (int'(waddr) / PAGE))) begin
            mem[i] <= 8'hFF;
         end
      end
      // Programming can only clear bits
      if (wr) begin
         mem[waddr] <= mem[waddr] & wdata;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rdata_r <= 8'h00;
      end else begin
         rdata_r <= mem[raddr];
      end
   end

   assign rdata = rdata_r;
endmodule

// ---- fmg_props.sv ----
// Checker: port-level properties of the flash modify guard
`timescale 1ns/10ps
module fmg_props #(
   parameter int PROG = 4
) (
   // Clock and reset
   input wire logic       clock,
   input wire logic       rst_n,
   // Watched ports
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic       code_rd,
   input wire logic       code_fetch,
   input wire logic       xdata_wr,
   input wire logic       irq_in,
   input wire logic       irq_hold,
   input wire logic       idle_wake,
   input wire logic       core_run,
   input wire logic       flash_busy,
   input wire logic       fault_reset_req,
   input wire logic       sense_enable,
   input wire logic       row_change,
   input wire logic       code_rdata_bad
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   int unsigned busy_cnt;
   always_ff @(posedge clock or negedge rst_n)
      if (!rst_n) busy_cnt <= 0;
      else busy_cnt <= flash_busy ? busy_cnt + 1 : 0;
   rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data not idle");
   fault_cause_a: assert property (fault_reset_req |-> $past(xdata_wr) && !flash_busy)
      else $error("fault pulse without refused access");
   busy_cause_a: assert property ($rose(flash_busy) |-> $past(xdata_wr))
      else $error("busy without modify access");
   busy_len_a: assert property ($fell(flash_busy) |-> busy_cnt == PROG)
      else $error("busy length wrong");
   irq_held_a: assert property (flash_busy && irq_in |-> irq_hold)
      else $error("request not held during modify");
   irq_free_a: assert property (irq_hold |-> irq_in && flash_busy)
      else $error("request held outside modify");
   sense_on_a: assert property (code_rd |-> sense_enable)
      else $error("sense enable missing on access");
   sense_off_a: assert property (sense_enable |-> code_rd || xdata_wr || $past(code_rd)
      || $past(xdata_wr))
      else $error("sense enable outside access");
   wake_time_a: assert property (idle_wake |=> !core_run [*3] ##1 core_run)
      else $error("wake time wrong");
   row_cause_a: assert property (row_change |-> $past(code_rd))
      else $error("row flag without read");
   bad_cause_a: assert property (code_rdata_bad |-> $past(code_rd && code_fetch))
      else $error("bad flag without fetch");
endmodule
bind fmg_top fmg_props #(.PROG(PROG)) u_props (.clock(clock), .rst_n(rst_n),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .code_rd(code_rd), .code_fetch(code_fetch),
   .xdata_wr(xdata_wr), .irq_in(irq_in), .irq_hold(irq_hold), .idle_wake(idle_wake),
   .core_run(core_run), .flash_busy(flash_busy), .fault_reset_req(fault_reset_req),
   .sense_enable(sense_enable), .row_change(row_change), .code_rdata_bad(code_rdata_bad));

// ---- fmg_core_model.sv ----
// Partner: core-side master issuing register, code read and flash write cycles
`timescale 1ns/10ps
module fmg_core_model
   import fmg_pkg::*;
(
   // Clock
   input  wire logic        clock,
   // Register port
   output logic [7:0]       reg_addr,
   output logic [7:0]       reg_wdata,
   output logic             reg_wr,
   output logic             reg_rd,
   input  wire logic [7:0]  reg_rdata,
   // Code read and external-data write
   output logic             code_rd,
   output logic             code_fetch,
   output logic [13:0]      code_addr,
   input  wire logic [7:0]  code_rdata,
   input  wire logic        code_rdata_bad,
   input  wire logic        row_change,
   output logic             xdata_wr,
   output logic [13:0]      xdata_addr,
   output logic [7:0]       xdata_wdata
);
   initial begin
      {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
      {code_rd, code_fetch, code_addr, xdata_wr, xdata_addr, xdata_wdata} = '0;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
      reg_wdata <= ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic crd(input logic [13:0] a, input logic f, output logic [7:0] d,
                      output logic bad, output logic row);
      @(posedge clock);
      code_addr <= a;
      code_fetch <= f;
      code_rd <= 1'b1;
      @(posedge clock);
      code_rd <= 1'b0;
      code_fetch <= 1'b0;
      #1;
      d = code_rdata;
      bad = code_rdata_bad;
      row = row_change;
   endtask
   task automatic xwr(input logic [13:0] a, input logic [7:0] d);
      @(posedge clock);
      xdata_addr <= a;
      xdata_wdata <= d;
      xdata_wr <= 1'b1;
      @(posedge clock);
      xdata_wr <= 1'b0;
      xdata_wdata <= ~d;
      #1;
   endtask
   task automatic unlock();
      wr(FMG_ADDR_KEY, FMG_KEY1);
      wr(FMG_ADDR_KEY, FMG_KEY2);
   endtask
   // Whole-value writes only, power-on flag always set
   task automatic sup_on();
      wr(FMG_ADDR_SUPMON, FMG_SUPMON_RST);
      wr(FMG_ADDR_RSTCAUSE, 8'h02);
   endtask
endmodule

// ---- testbench.sv ----
// Testbench: directed scenarios for the flash modify guard block
`timescale 1ns/10ps
module testbench
   import fmg_pkg::*;
;
   logic        clock = 1'b0, rst_n = 1'b0, por_event = 1'b0, irq_in = 1'b0;
   logic        idle_wake = 1'b0, b, r;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, code_rdata, xdata_wdata, d;
   logic        reg_wr, reg_rd, code_rd, code_fetch, code_rdata_bad, xdata_wr;
   logic        irq_hold, core_run, flash_busy, fault_reset_req, sense_enable, row_change;
   logic [13:0] code_addr, xdata_addr;
   int          failures = 0, checked = 0, cycles = 0;
   always #12.5 clock = ~clock;
   fmg_top u_dut (.clock(clock), .rst_n(rst_n), .por_event(por_event), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .code_rd(code_rd), .code_fetch(code_fetch), .code_addr(code_addr),
      .code_rdata(code_rdata), .code_rdata_bad(code_rdata_bad), .xdata_wr(xdata_wr),
      .xdata_addr(xdata_addr), .xdata_wdata(xdata_wdata), .irq_in(irq_in),
      .irq_hold(irq_hold), .idle_wake(idle_wake), .core_run(core_run),
      .flash_busy(flash_busy), .fault_reset_req(fault_reset_req),
      .sense_enable(sense_enable), .row_change(row_change));
   fmg_core_model u_core (.clock(clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .code_rd(code_rd),
      .code_fetch(code_fetch), .code_addr(code_addr), .code_rdata(code_rdata),
      .code_rdata_bad(code_rdata_bad), .row_change(row_change), .xdata_wr(xdata_wr),
      .xdata_addr(xdata_addr), .xdata_wdata(xdata_wdata));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic summarize();
      $display("Checks %0d, failures %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         $display("[FAIL] %0t run did not finish", $time);
         summarize();
      end
   end
   task automatic wait_idle();
      for (int i = 0; i < 12 && flash_busy === 1'b1; i++) @(posedge clock) #1;
   endtask
   task automatic modify(input logic [13:0] a, input logic [7:0] v);
      // Core unlocks with both keys, then issues one external-data write
      u_core.unlock();
      u_core.xwr(a, v);
   endtask
   task automatic t_reset();
      u_core.rd(FMG_ADDR_PSC, d);
      chk(d, FMG_PSC_RST);
      u_core.rd(FMG_ADDR_SCALE, d);
      chk(d, FMG_SCALE_RST);
      u_core.rd(FMG_ADDR_SUPMON, d);
      chk(d & 8'h80, 8'h80);
      u_core.rd(FMG_ADDR_RSTCAUSE, d);
      chk(d & 8'h42, 8'h02);
      u_core.rd(8'h00, d);
      chk(d, 8'h00);
      u_core.crd(FMG_ID_ADDR, 1'b0, d, b, r);
      chk(d, FMG_ID_VALUE);
   endtask
   task automatic t_modify();
      @(posedge clock) irq_in <= 1'b1;
      u_core.wr(FMG_ADDR_PSC, 8'h03);
      modify(14'h0005, 8'h00);
      chk({7'h00, flash_busy}, 8'h01);
      chk({7'h00, irq_hold}, 8'h01);
      wait_idle();
      chk({7'h00, irq_hold}, 8'h00);
      u_core.crd(14'h0010, 1'b0, d, b, r);
      chk(d, 8'hFF);
      u_core.wr(FMG_ADDR_PSC, 8'h01);
      modify(14'h0010, 8'h3C);
      wait_idle();
      u_core.crd(14'h0010, 1'b0, d, b, r);
      chk(d, 8'h3C);
      u_core.xwr(14'h0010, 8'h00);
      chk({7'h00, flash_busy}, 8'h00);
      u_core.wr(FMG_ADDR_KEY, FMG_KEY2);
      u_core.wr(FMG_ADDR_KEY, FMG_KEY1);
      u_core.xwr(14'h0010, 8'h00);
      chk({7'h00, flash_busy}, 8'h00);
      u_core.wr(FMG_ADDR_PSC, 8'h02);
      modify(14'h0010, 8'h00);
      chk({7'h00, flash_busy}, 8'h00);
      u_core.crd(14'h0010, 1'b0, d, b, r);
      chk(d, 8'h3C);
      @(posedge clock) irq_in <= 1'b0;
   endtask
   task automatic t_fault();
      u_core.wr(FMG_ADDR_PSC, 8'h01);
      u_core.wr(FMG_ADDR_SUPMON, 8'h00);
      modify(14'h0020, 8'h00);
      chk({7'h00, fault_reset_req}, 8'h01);
      chk({7'h00, flash_busy}, 8'h00);
      u_core.rd(FMG_ADDR_RSTCAUSE, d);
      chk(d & 8'h40, 8'h40);
      // Enable set while monitor is off, monitor back before the access
      u_core.wr(FMG_ADDR_PSC, 8'h01);
      u_core.sup_on();
      modify(14'h0020, 8'h00);
      chk({7'h00, flash_busy}, 8'h01);
      wait_idle();
      u_core.crd(14'h0020, 1'b0, d, b, r);
      chk(d, 8'h00);
      u_core.wr(FMG_ADDR_RSTCAUSE, 8'h00);
      modify(14'h0020, 8'h00);
      chk({7'h00, fault_reset_req}, 8'h01);
      @(posedge clock) por_event <= 1'b1;
      @(posedge clock) por_event <= 1'b0;
      u_core.rd(FMG_ADDR_SUPMON, d);
      chk(d & 8'h80, 8'h80);
      u_core.rd(FMG_ADDR_RSTCAUSE, d);
      chk(d & 8'h42, 8'h02);
      u_core.wr(FMG_ADDR_PSC, 8'h00);
   endtask
   task automatic t_read_path();
      logic [13:0] ra [4] = '{14'h003E, 14'h003F, 14'h0040, 14'h0080};
      logic        rc [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
      u_core.wr(FMG_ADDR_SCALE, 8'h40);
      u_core.rd(FMG_ADDR_SCALE, d);
      chk(d, 8'h40);
      u_core.wr(FMG_ADDR_SCALE, 8'h00);
      for (int i = 1; i <= 4; i++) begin
         u_core.crd(14'(14'h0100 + i), 1'b1, d, b, r);
         chk({7'h00, b}, {7'h00, i == 3});
      end
      for (int i = 0; i < 4; i++) begin
         u_core.crd(ra[i], 1'b0, d, b, r);
         chk({7'h00, r}, {7'h00, rc[i]});
      end
   endtask
   task automatic t_idle();
      @(posedge clock) idle_wake <= 1'b1;
      @(posedge clock) idle_wake <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         #1 chk({7'h00, core_run}, {7'h00, i == 3});
         @(posedge clock);
      end
   endtask
   initial begin
      repeat (12) @(posedge clock);
      rst_n <= 1'b1;
      t_reset();
      t_modify();
      t_fault();
      t_read_path();
      t_idle();
      summarize();
   end
endmodule
